// ==== common/pps_regs.svh ====
`ifndef PPS_REGS_SVH
`define PPS_REGS_SVH
// Command codes carried in the cyclic frame.
`define PPS_CMD_NORMAL      8'h10
`define PPS_CMD_START       8'h17
// Profile type selector for absolute positioning.
`define PPS_TYPE_ABS        8'h10
// Error code reported when the mode is altered during motion.
`define PPS_ERR_MODE_CHANGE 16'h0104
`define PPS_ERR_NONE        16'h0000
// Bit of the update trigger configuration that enables on-the-fly updates.
`define PPS_UPD_BIT         5
// Acceleration scale: one setting step is 10000 command units per s^2.
`define PPS_ACC_STEP        32'd10000
// Control tick: the profile is advanced every tick of this many ns, which is 100 clocks of 10 ns.
`define PPS_TICK_NS         1000
`define PPS_CLK_NS          10
`define PPS_TICK_CYC        (`PPS_TICK_NS / `PPS_CLK_NS)
// Saturation limits for converted homing velocities.
`define PPS_VEL_MAX         32'h7FFFFFFF
`define PPS_VEL_MIN         32'h80000001
// Defaults for host-held settings.
`define PPS_ACC_RST         16'h0001
`define PPS_WIN_RST         32'h0000000A
`define PPS_NEAR_RST        32'h00000064
// Host register offsets, one aligned word each.
`define PPS_A_CTRL          8'h00
`define PPS_A_TARGET_POSITION_VALUE          8'h04
`define PPS_A_TARGET_SPEED_VALUE          8'h08
`define PPS_A_STAT          8'h0C
`define PPS_A_INTERNAL_COMMAND_POSITION          8'h10
// Host control reset value: normal code with the absolute type.
`define PPS_CTRL_RST        32'h00001010
// Clocks between two cyclic frames.
`define PPS_FRAME_CYC       100
`endif

// ==== common/pps_pkg.sv ====
package pps_pkg;
    typedef logic [7:0]  pps_code_t;
    typedef logic [31:0] pps_word_t;
    // Cyclic command frame from host to driver.
    typedef struct packed {
        pps_code_t cmd;
        pps_code_t ptype;
        pps_code_t latch_sel;
        pps_word_t target_position_value;
        pps_word_t target_speed_value;
    } pps_cmd_t;
    // Cyclic response frame from driver to host.
    typedef struct packed {
        pps_code_t   cmd_echo;
        pps_code_t   type_echo;
        logic        in_progress;
        logic        near;
        logic        in_position;
        logic        cmd_error;
        logic [15:0] err_code;
        pps_word_t   internal_command_position;
    } pps_rsp_t;
endpackage : pps_pkg

// ==== common/pps_link_if.sv ====
`timescale 1ns/10ps
// Cyclic command/response link; a new frame is valid when frame_stb pulses.
interface pps_link_if;
    import pps_pkg::*;
    logic     frame_stb;
    pps_cmd_t cmd;
    pps_rsp_t rsp;
    modport device (input frame_stb, input cmd, output rsp);
    modport host   (output frame_stb, output cmd, input rsp);
endinterface : pps_link_if

// ==== rtl/pps_host.sv ====
`timescale 1ns/10ps
`include "pps_regs.svh"
// Host end: takes orders over APB and issues one cyclic frame per period.
module pps_host (
    input  wire logic           CLK_I,     // System clock.
    input  wire logic           RST_N_I,   // Asynchronous reset, active low.
    input  wire logic           PSEL_I,    // APB select.
    input  wire logic           PENABLE_I, // APB enable.
    input  wire logic           PWRITE_I,  // APB direction.
    input  wire logic [7:0]     PADDR_I,   // APB byte address.
    input  wire logic [31:0]    PWDATA_I,  // APB write data.
    output logic      [31:0]    PRDATA_O,  // APB read data.
    output logic                PREADY_O,  // APB ready.
    output logic                PSLVERR_O, // APB error.
    pps_link_if.host            link       // Link to the driver.
);
    import pps_pkg::*;
    localparam logic [7:0] A_CTRL = `PPS_A_CTRL;
    localparam logic [7:0] A_TARGET_POSITION_VALUE = `PPS_A_TARGET_POSITION_VALUE;
    localparam logic [7:0] A_TARGET_SPEED_VALUE = `PPS_A_TARGET_SPEED_VALUE;
    localparam logic [7:0] A_STAT = `PPS_A_STAT;
    localparam logic [7:0] A_INTERNAL_COMMAND_POSITION = `PPS_A_INTERNAL_COMMAND_POSITION;
    localparam int         PERIOD = `PPS_FRAME_CYC;

    logic [31:0] ctrl_ff, target_position_value_ff, target_speed_value_ff;
    logic [31:0] rd_mux;
    logic [6:0]  per_ff;
    pps_rsp_t    rsp_ff;
    wire         wr      = PSEL_I & PENABLE_I & PWRITE_I;
    wire         hit     = (PADDR_I <= A_INTERNAL_COMMAND_POSITION) && (PADDR_I[1:0] == 2'b00);
    wire         tick    = (per_ff == 7'(PERIOD - 1));

    // Zero-wait slave; unmapped addresses answer with an error.
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;
    always_comb begin
        case (PADDR_I)
            A_CTRL:  rd_mux = ctrl_ff;
            A_TARGET_POSITION_VALUE:  rd_mux = target_position_value_ff;
            A_TARGET_SPEED_VALUE:  rd_mux = target_speed_value_ff;
            A_STAT:  rd_mux = {rsp_ff.err_code, rsp_ff.cmd_echo, 4'h0,
                               rsp_ff.in_progress, rsp_ff.near,
                               rsp_ff.in_position, rsp_ff.cmd_error};
            A_INTERNAL_COMMAND_POSITION:  rd_mux = rsp_ff.internal_command_position;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Read data is caught in the setup cycle, so it stands from a flop in the access cycle.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PRDATA_O <= 32'h00000000;
        end else if (PSEL_I & ~PENABLE_I) begin
            PRDATA_O <= rd_mux;
        end
    end

    // Software writes command code, type and latch selector in CTRL; setup of
    // the profile constants before a start is software's duty.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_ff <= `PPS_CTRL_RST;
            target_position_value_ff <= 32'h00000000;
            target_speed_value_ff <= 32'h00000000;
        end else if (wr) begin
            if (PADDR_I == A_CTRL) ctrl_ff <= PWDATA_I;
            if (PADDR_I == A_TARGET_POSITION_VALUE) target_position_value_ff <= PWDATA_I;
            if (PADDR_I == A_TARGET_SPEED_VALUE) target_speed_value_ff <= PWDATA_I;
        end
    end

    // Frame period counter and response capture.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            per_ff <= 7'h00;
            rsp_ff <= '0;
        end else begin
            per_ff <= tick ? 7'h00 : per_ff + 7'h01;
            rsp_ff <= link.rsp;
        end
    end

    // Frame fields: cmd[7:0], type[15:8], latch[23:16].
    assign link.frame_stb     = tick;
    assign link.cmd.cmd       = ctrl_ff[7:0];
    assign link.cmd.ptype     = ctrl_ff[15:8];
    assign link.cmd.latch_sel = ctrl_ff[23:16];
    assign link.cmd.target_position_value      = target_position_value_ff;
    assign link.cmd.target_speed_value      = target_speed_value_ff;
endmodule : pps_host

// ==== rtl/pps_device.sv ====
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "pps_regs.svh"
// Functional notes
// - Acceleration constant ramps speed up.
// - Deceleration constant ramps speed down.
// - Hold signed post-latch travel setting.
// - Homing polarity bit selects search direction.
// - Second homing variant always homes positive.
// - Fast homing velocity clamped to top speed.
// - Slow homing velocity used for slow phase.
// - Converted rpm velocity saturates to signed range.
// - Zero homing velocity becomes one.
// - Host homes or reads position first.
// - Normal code alone starts nothing.
// - Host sends absolute type, target, speed.
// - Host zeros latch selector, picks monitor.
// - Code change 10h to 17h starts motion.
// - Host checks echoes, active status, errors.
// - Bit5 clear: updates apply on next start.
// - Bit5 set: updates apply while 17h held.
// - Nearer target: stop, then move again.
// - Mode change during motion raises error 0104h.
// - Near, then done, then in-position flags.
module pps_device (
    input  wire logic                  CLK_I,         // System clock.
    input  wire logic                  RST_N_I,       // Asynchronous reset, active low.
    input  wire logic [15:0]           ACCEL_I,       // Profile accel constant.
    input  wire logic [15:0]           DECEL_I,       // Profile decel constant.
    input  wire logic [31:0]           LATCH_TRAV_I,  // Post-latch travel setting.
    input  wire logic                  HOME_POL_I,    // Homing polarity setting.
    input  wire logic                  HOME_VAR2_I,   // Second homing variant selected.
    input  wire logic [31:0]           HOME_FAST_I,   // Fast homing velocity.
    input  wire logic [31:0]           HOME_SLOW_I,   // Slow homing velocity.
    input  wire logic                  VEL_RPM_I,     // Velocity unit is r/min.
    input  wire logic [31:0]           RPM_SCALE_I,   // Command units per s per r/min.
    input  wire logic [31:0]           TOP_SPEED_I,   // Motor top speed, units per s.
    input  wire logic [7:0]            UPD_CFG_I,     // Update trigger configuration.
    input  wire logic [31:0]           DONE_WIN_I,    // Position complete window.
    input  wire logic [31:0]           NEAR_RANGE_I,  // Neighborhood range.
    input  wire logic [31:0]           ACT_POS_I,     // Actual motor position.
    output logic      [31:0]           POST_TRAV_O,   // Held post-latch travel.
    output logic                       HOME_DIR_O,    // Homing direction, 1 is negative.
    output logic      [31:0]           HOME_FAST_O,   // Effective fast homing velocity.
    output logic      [31:0]           HOME_SLOW_O,   // Effective slow homing velocity.
    pps_link_if.device                 link           // Link to the host.
);
    import pps_pkg::*;
    typedef enum logic [1:0] {PPS_IDLE, PPS_RUN, PPS_STOP} pps_state_t;

    // Converts, saturates, clamps to top speed and replaces zero by one.
    function automatic logic [31:0] pps_eff_vel(input logic [31:0] v, input logic rpm,
                                                input logic [31:0] sc, input logic [31:0] top);
        logic signed [64:0] p;
        logic [31:0]        r;
        p = rpm ? $signed({33'b0, v}) * $signed({33'b0, sc}) : $signed({33'b0, v});
        r = (p > $signed({33'b0, `PPS_VEL_MAX})) ? `PPS_VEL_MAX : p[31:0];
        if (r > top) r = top;
        if (r == 32'h00000000) r = 32'h00000001;
        return r;
    endfunction : pps_eff_vel

    // Absolute difference of two signed positions.
    function automatic logic [31:0] pps_dist(input logic [31:0] a, input logic [31:0] b);
        logic signed [32:0] d;
        d = $signed({a[31], a}) - $signed({b[31], b});
        return d[32] ? 32'(-d) : d[31:0];
    endfunction : pps_dist

    pps_state_t  state_ff, nxt_state;
    logic [7:0]  cmd_ff, type_ff, latch_ff;
    logic [31:0] tgt_ff, spd_cmd_ff, pend_pos_ff, pend_spd_ff;
    logic [31:0] internal_command_position_ff, vel_ff, post_ff;
    logic [31:0] nxt_vel;
    logic [6:0]  tick_ff;
    logic        err_ff, near_ff, inpos_ff, stopped_ff, mov_neg_ff;
    logic [15:0] err_code_ff;

    wire        upd_live  = UPD_CFG_I[`PPS_UPD_BIT];
    wire        stb       = link.frame_stb;
    wire [7:0]  cmd_in    = link.cmd.cmd;
    wire        start_evt = stb & (cmd_ff == `PPS_CMD_NORMAL) & (cmd_in == `PPS_CMD_START);
    wire        mode_chg  = stb & (state_ff != PPS_IDLE) &
                            ((link.cmd.ptype != type_ff) | (link.cmd.latch_sel != latch_ff));
    wire        arg_chg   = stb & (cmd_in == `PPS_CMD_START) & (cmd_ff == `PPS_CMD_START) &
                            ((link.cmd.target_position_value != tgt_ff) | (link.cmd.target_speed_value != spd_cmd_ff));
    wire        tick      = (tick_ff == 7'(`PPS_TICK_CYC - 1));
    wire [31:0] remain    = pps_dist(tgt_ff, internal_command_position_ff);
    wire        dir_neg   = $signed(tgt_ff) < $signed(internal_command_position_ff);
    // A stop keeps the old heading; turning at once would make the command jump back.
    wire        step_neg  = (state_ff == PPS_STOP) ? mov_neg_ff : dir_neg;
    wire [31:0] acc_step  = {16'h0000, ACCEL_I};
    wire [31:0] dec_step  = {16'h0000, DECEL_I};
    // Stopping distance estimate v*v/(2*dec); v scaled per tick.
    wire [63:0] stop_num  = {32'h0, vel_ff} * {32'h0, vel_ff};
    wire [63:0] stop_den  = {31'h0, dec_step, 1'b0};
    wire        must_dec  = (stop_num >= stop_den * {32'h0, remain});
    // A new target behind the command position forces a stop first.
    wire        overshoot = (vel_ff != 32'h0) &&
                            (dir_neg != ($signed(link.cmd.target_position_value) < $signed(internal_command_position_ff)) ||
                             pps_dist(link.cmd.target_position_value, internal_command_position_ff) < remain);

    // Homing and latch settings held or derived for the homing logic.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            post_ff     <= 32'h00000000;
            HOME_DIR_O  <= 1'b0;
            HOME_FAST_O <= 32'h00000001;
            HOME_SLOW_O <= 32'h00000001;
        end else begin
            post_ff     <= LATCH_TRAV_I;
            HOME_DIR_O  <= HOME_VAR2_I ? 1'b0 : HOME_POL_I;
            HOME_FAST_O <= pps_eff_vel(HOME_FAST_I, VEL_RPM_I, RPM_SCALE_I, TOP_SPEED_I);
            HOME_SLOW_O <= pps_eff_vel(HOME_SLOW_I, VEL_RPM_I, RPM_SCALE_I, TOP_SPEED_I);
        end
    end
    assign POST_TRAV_O = post_ff;

    // Motion state: only a 10h-to-17h edge starts motion; a live update acts only while running.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PPS_IDLE: if (start_evt && !mode_chg) nxt_state = PPS_RUN;
            PPS_RUN: begin
                if (mode_chg) nxt_state = PPS_IDLE;
                else if (arg_chg && upd_live && overshoot) nxt_state = PPS_STOP;
                else if (tick && remain == 32'h0 && vel_ff <= dec_step) nxt_state = PPS_IDLE;
            end
            PPS_STOP: if (mode_chg) nxt_state = PPS_IDLE;
                      else if (tick && nxt_vel == 32'h0) nxt_state = PPS_RUN;
            default: nxt_state = PPS_IDLE;
        endcase
    end

    // Velocity ramp toward target speed, then down into the target.
    always_comb begin
        nxt_vel = vel_ff;
        if (state_ff == PPS_STOP || (state_ff == PPS_RUN && (must_dec || vel_ff > spd_cmd_ff)))
            nxt_vel = (vel_ff > dec_step) ? vel_ff - dec_step : 32'h0;
        else if (state_ff == PPS_RUN && vel_ff < spd_cmd_ff)
            nxt_vel = (spd_cmd_ff - vel_ff > acc_step) ? vel_ff + acc_step : spd_cmd_ff;
        if (state_ff == PPS_RUN && nxt_vel == 32'h0 && remain != 32'h0)
            nxt_vel = (remain < acc_step) ? remain : acc_step;
    end

    // Profile generator and frame capture.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_ff    <= PPS_IDLE;
            cmd_ff      <= `PPS_CMD_NORMAL;
            type_ff     <= `PPS_TYPE_ABS;
            latch_ff    <= 8'h00;
            tgt_ff      <= 32'h00000000;
            spd_cmd_ff  <= 32'h00000000;
            pend_pos_ff <= 32'h00000000;
            pend_spd_ff <= 32'h00000000;
            internal_command_position_ff     <= 32'h00000000;
            vel_ff      <= 32'h00000000;
            tick_ff     <= 7'h00;
            err_ff      <= 1'b0;
            err_code_ff <= `PPS_ERR_NONE;
            near_ff     <= 1'b0;
            stopped_ff  <= 1'b1;
            mov_neg_ff  <= 1'b0;
            inpos_ff    <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tick_ff  <= tick ? 7'h00 : tick_ff + 7'h01;
            if (stb) begin
                cmd_ff <= cmd_in;
                if (cmd_in == `PPS_CMD_NORMAL) begin
                    pend_pos_ff <= link.cmd.target_position_value;
                    pend_spd_ff <= link.cmd.target_speed_value;
                end
                if (state_ff == PPS_IDLE) begin
                    type_ff  <= link.cmd.ptype;
                    latch_ff <= link.cmd.latch_sel;
                end
            end
            if (start_evt) begin
                tgt_ff     <= pend_pos_ff;
                spd_cmd_ff <= pend_spd_ff;
                err_ff     <= 1'b0;
                err_code_ff <= `PPS_ERR_NONE;
            end else if (arg_chg && upd_live) begin
                tgt_ff     <= link.cmd.target_position_value;
                spd_cmd_ff <= link.cmd.target_speed_value;
            end
            if (mode_chg) begin
                err_ff      <= 1'b1;
                err_code_ff <= `PPS_ERR_MODE_CHANGE;
                vel_ff      <= 32'h0;
            end else if (tick) begin
                vel_ff <= (state_ff == PPS_IDLE) ? 32'h0 : nxt_vel;
                if (state_ff != PPS_IDLE) begin
                    if (state_ff == PPS_RUN) mov_neg_ff <= dir_neg;
                    if (nxt_vel >= remain && state_ff == PPS_RUN) internal_command_position_ff <= tgt_ff;
                    else if (step_neg) internal_command_position_ff <= internal_command_position_ff - nxt_vel;
                    else internal_command_position_ff <= internal_command_position_ff + nxt_vel;
                end
            end
            // Flag order: near first, done on output end, then in-position.
            near_ff    <= (state_ff != PPS_IDLE) && (remain < NEAR_RANGE_I);
            stopped_ff <= (nxt_state == PPS_IDLE);
            inpos_ff   <= (nxt_state == PPS_IDLE) && stopped_ff &&
                          (pps_dist(internal_command_position_ff, ACT_POS_I) < DONE_WIN_I);
        end
    end

    // Response frame, all from flip-flops.
    assign link.rsp.cmd_echo    = cmd_ff;
    assign link.rsp.type_echo   = type_ff;
    assign link.rsp.in_progress = (state_ff != PPS_IDLE);
    assign link.rsp.near        = near_ff;
    assign link.rsp.in_position = inpos_ff;
    assign link.rsp.cmd_error   = err_ff;
    assign link.rsp.err_code    = err_code_ff;
    assign link.rsp.internal_command_position        = internal_command_position_ff;
endmodule : pps_device

// ==== testbench/pps_properties.sv ====
`timescale 1ns/10ps
`include "pps_regs.svh"
// Watches the link that joins the host end to the driver end.
module pps_checker (
    input wire logic              CLK_I,     // Clock.
    input wire logic              RST_N_I,   // Reset, active low.
    input wire logic              frame_stb, // Frame strobe.
    input wire pps_pkg::pps_cmd_t cmd,       // Command frame.
    input wire pps_pkg::pps_rsp_t rsp        // Response frame.
);
    import pps_pkg::*;
    logic [7:0] last_cmd_ff; // Code of the previous frame.
    // A start is an edge between two frames, so both codes are looked at.
    wire start_w = frame_stb && cmd.cmd == `PPS_CMD_START && cmd.ptype == `PPS_TYPE_ABS
                   && last_cmd_ff == `PPS_CMD_NORMAL;
    wire mode_w  = frame_stb && rsp.in_progress
                   && (cmd.ptype != rsp.type_echo || cmd.latch_sel != 8'h00);
    // Keep the code of the last frame; a reset forgets it so no false edge is seen.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            last_cmd_ff <= 8'h00;
        end else if (frame_stb) begin
            last_cmd_ff <= cmd.cmd;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Start, echo, error and completion relations on the response frame.
    start_edge_a: assert property (
        start_w |=> rsp.in_progress && rsp.cmd_echo == `PPS_CMD_START)
        else $error("start edge did not start motion");
    normal_idle_a: assert property (
        frame_stb && cmd.cmd == `PPS_CMD_NORMAL && !rsp.in_progress |=> !rsp.in_progress)
        else $error("normal code started motion");
    mode_err_a: assert property (
        mode_w |=> rsp.cmd_error && rsp.err_code == `PPS_ERR_MODE_CHANGE)
        else $error("mode change during motion not refused");
    err_code_a: assert property (
        rsp.err_code == (rsp.cmd_error ? `PPS_ERR_MODE_CHANGE : `PPS_ERR_NONE))
        else $error("error code does not match error flag");
    inpos_order_a: assert property (
        rsp.in_position |-> !rsp.in_progress)
        else $error("in position while still moving");
    near_first_a: assert property (
        $fell(rsp.in_progress) && !rsp.cmd_error |-> rsp.near || $past(rsp.near))
        else $error("motion ended without neighborhood flag");
    echo_follow_a: assert property (
        frame_stb |=> rsp.cmd_echo == $past(cmd.cmd))
        else $error("command echo does not follow frame");
    idle_hold_a: assert property (
        !rsp.in_progress ##1 !rsp.in_progress |-> $stable(rsp.internal_command_position))
        else $error("command position moved while idle");
    stb_pulse_a: assert property (
        frame_stb |=> !frame_stb [*8])
        else $error("frame strobe too long or too close");
    cover property (start_w ##1 rsp.in_progress);
    cover property (mode_w ##1 rsp.cmd_error);
    cover property ($rose(rsp.in_position));
endmodule : pps_checker

// ==== testbench/tb_profile_position_sequencer.sv ====
`timescale 1ns/10ps
`include "pps_regs.svh"
// Joins both ends on one link and drives the host over APB.
module tb_profile_position_sequencer;
    import pps_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, perr;
    logic        hpol, hvar2, vrpm, hdir;
    logic [7:0]  paddr, upd;
    logic [15:0] acc_set, dec_set;
    logic [31:0] pwdata, prdata, r, ltrav, hfast, hslow, rscale, top, act, ptrav, efo, eso;
    int          n_fail, tests_run;
    pps_link_if  link_if ();
    pps_host u_pps_host (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .link(link_if));
    pps_device u_pps_device (.CLK_I(clk), .RST_N_I(rst_n), .ACCEL_I(acc_set),
        .DECEL_I(dec_set), .LATCH_TRAV_I(ltrav), .HOME_POL_I(hpol), .HOME_VAR2_I(hvar2),
        .HOME_FAST_I(hfast), .HOME_SLOW_I(hslow), .VEL_RPM_I(vrpm), .RPM_SCALE_I(rscale),
        .TOP_SPEED_I(top), .UPD_CFG_I(upd), .DONE_WIN_I(32'h0000000A),
        .NEAR_RANGE_I(32'h00000064), .ACT_POS_I(act), .POST_TRAV_O(ptrav),
        .HOME_DIR_O(hdir), .HOME_FAST_O(efo), .HOME_SLOW_O(eso), .link(link_if));
    pps_checker u_pps_checker (.CLK_I(clk), .RST_N_I(rst_n), .frame_stb(link_if.frame_stb),
        .cmd(link_if.cmd), .rsp(link_if.rsp));
    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // The motor follows the command one clock late, so in-position can settle.
    always @(posedge clk) begin
        act <= link_if.rsp.internal_command_position;
    end
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        r = prdata;
        perr = pslverr;
        if (k >= 16) begin
            n_fail++;
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Poll one status bit; a run that never settles is a failure.
    task automatic wait_st(input int b, input logic v);
        for (int k = 0; k < 8000; k++) begin
            apb(1'b0, 8'h0C, 32'h0);
            if (r[b] === v) return;
        end
        n_fail++;
        finish_test();
    endtask : wait_st
    // Wait for the next frame edge; a frame that does not come is a failure.
    task automatic wait_frame();
        for (int k = 0; k < 200; k++) begin
            @(posedge clk);
            if (link_if.frame_stb === 1'b1) return;
        end
        n_fail++;
        finish_test();
    endtask : wait_frame
    // Load a target under the normal code, prove nothing moves, then start.
    task automatic go(input logic [31:0] tp);
        logic [31:0] base;
        apb(1'b0, 8'h10, 32'h0);
        base = r;
        apb(1'b1, 8'h04, tp);
        apb(1'b1, 8'h00, 32'h00001010);
        repeat (250) @(posedge clk);
        apb(1'b0, 8'h0C, 32'h0);
        chk(r & 32'h00000008, 32'h0);
        apb(1'b1, 8'h00, 32'h00001017);
        // Two ticks after the start edge the command has moved by one step plus two steps.
        wait_frame();
        repeat (250) @(posedge clk);
        apb(1'b0, 8'h0C, 32'h0);
        chk(r & 32'h0000FF09, 32'h00001708);
        apb(1'b0, 8'h10, 32'h0);
        chk(r, (tp > base) ? base + 3 * acc_set : base - 3 * acc_set);
    endtask : go
    // Wait for completion and check where the command ended.
    task automatic done(input logic [31:0] tp);
        wait_st(1, 1'b1);
        apb(1'b0, 8'h10, 32'h0);
        chk(r, tp);
    endtask : done
    // Apply homing settings and compare direction and effective velocities.
    task automatic home(input logic p, v2, rpm, input logic [31:0] f, s, sc, t,
                        input logic ed, input logic [31:0] ef, es);
        hpol <= p;
        hvar2 <= v2;
        vrpm <= rpm;
        hfast <= f;
        hslow <= s;
        rscale <= sc;
        top <= t;
        repeat (4) @(posedge clk);
        chk({31'h0, hdir}, {31'h0, ed});
        chk(efo, ef);
        chk(eso, es);
    endtask : home
    // Main sequence: reset, settings, then motion under both update policies.
    initial begin
        {rst_n, psel, penable, pwrite, hpol, hvar2, vrpm} = 7'h00;
        {paddr, upd, pwdata, ltrav, hfast, hslow, rscale, top} = 208'h0;
        {acc_set, dec_set} = 32'h00030002;
        n_fail = 0;
        tests_run = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h0C, 32'h0);
        chk(r, 32'h00001000);
        apb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h00001010);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, perr}, 32'h1);
        ltrav <= 32'hC0000001;
        home(1, 0, 0, 32'h0, 32'h0, 32'h0, 32'hFFFF, 1, 32'h1, 32'h1);
        chk(ptrav, 32'hC0000001);
        home(1, 1, 0, 32'd5000, 32'd200, 32'h0, 32'd3000, 0, 32'd3000, 32'd200);
        home(0, 0, 1, 32'h7FFFFFFF, 32'd3, 32'd1000, 32'h7FFFFFFF, 0,
             32'h7FFFFFFF, 32'd3000);
        apb(1'b1, 8'h08, 32'd50);
        go(32'd1000);
        done(32'd1000);
        go(32'd3000);
        repeat (500) @(posedge clk);
        apb(1'b1, 8'h04, 32'd1500);
        done(32'd3000);
        go(32'd500);
        done(32'd500);
        upd <= 8'h20;
        go(32'd5000);
        repeat (3000) @(posedge clk);
        apb(1'b1, 8'h04, 32'd700);
        done(32'd700);
        upd <= 8'h00;
        go(32'd2000);
        apb(1'b1, 8'h00, 32'h00001117);
        repeat (300) @(posedge clk);
        apb(1'b0, 8'h0C, 32'h0);
        chk(r & 32'hFFFF0009, 32'h01040001);
        finish_test();
    end
endmodule : tb_profile_position_sequencer
